// ---- hdl/branch_shift_flag_exec.sv ----
/*
  Execution unit for relative branches, shifts and rotates, single flag
  writes, I/O bit forcing, transfer-flag bit moves and X-pointer loads.
  Assumes a classic Wishbone master issuing instructions and a data space
  that answers reads with ds_ack, and an I/O space that applies bit pulses.
*/
`default_nettype none
module branch_shift_flag_exec
  import exec_pkg::*;
#(
  parameter int PC_W = 16
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // Wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // Data-space read port
  output ds_req_s            ds_req,
  input  wire logic          ds_ack,
  input  wire logic [7:0]    ds_rdata,
  // I/O bit port
  output io_bit_s            io_bit,
  // Program counter
  output logic [PC_W-1:0]    pc
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_BR_TAKEN, ST_LD_ADDR, ST_LD_WAIT
  } state_e;

  state_e          state_reg;
  instr_s          instr_reg;
  logic [7:0]      flags_reg;
  logic [15:0]     xptr_reg;
  logic [7:0]      regs_reg [16];
  logic            taken_reg;
  logic [PC_W-1:0] pc_reg;
  logic            ack_reg;
  logic [31:0]     rdata_reg;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic        bus_fire;
  logic        wr_fire;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic        regs_hit;
  logic [3:0]  regs_idx;
  logic        issue_fire;

  assign bus_fire   = cyc_i && stb_i && !ack_reg;
  assign wr_fire    = bus_fire && we_i;
  assign wmask      = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wdata      = dat_i & wmask;
  assign regs_hit   = (adr_i[7:6] == ADR_REGS[7:6]);
  assign regs_idx   = adr_i[5:2];
  // Writes while busy are dropped: one instruction in flight keeps the
  // flag and register hazards trivial.
  assign issue_fire = wr_fire && (adr_i == ADR_ISSUE) && (state_reg == ST_IDLE);

  // ----------------------------------------------------------------------
  // Operand and result logic
  // ----------------------------------------------------------------------
  logic [7:0]      src;
  logic [7:0]      shift_res;
  logic            shift_c;
  logic            br_taken;
  logic [PC_W-1:0] br_target;

  assign src = regs_reg[instr_reg.rd];
  assign br_target = pc_reg + PC_W'(signed'(instr_reg.disp)) + PC_W'(1);

  always_comb begin
    shift_res = src;
    shift_c   = flags_reg[FLAG_C];
    unique case (instr_reg.op)
      OP_SHL: begin
        shift_res = {src[6:0], 1'b0};                 // see RULE10
        shift_c   = src[7];
      end
      OP_SHR: begin
        shift_res = {1'b0, src[7:1]};                 // see RULE11
        shift_c   = src[0];
      end
      OP_ROL: begin
        shift_res = {src[6:0], flags_reg[FLAG_C]};    // see RULE12
        shift_c   = src[7];
      end
      OP_ROR: begin
        shift_res = {flags_reg[FLAG_C], src[7:1]};    // see RULE13
        shift_c   = src[0];
      end
      OP_SHR_SIGNED: begin
        shift_res = {src[7], src[7:1]};               // see RULE14
        shift_c   = src[0];
      end
      default: begin
        shift_res = src;
        shift_c   = flags_reg[FLAG_C];
      end
    endcase
  end

  always_comb begin
    br_taken = 1'b0;
    unique case (instr_reg.op)
      OP_BR_CARRY_CLEAR,
      OP_BR_SAME_HIGHER:    br_taken = !flags_reg[FLAG_C];  // see RULE1
      OP_BR_LOWER:          br_taken = flags_reg[FLAG_C];   // see RULE2
      OP_BR_NEGATIVE:       br_taken = flags_reg[FLAG_N];   // see RULE3
      OP_BR_SIGNED_GE:      br_taken = !(flags_reg[FLAG_N] ^ flags_reg[FLAG_V]); // see RULE4
      OP_BR_SIGNED_LESS:    br_taken = flags_reg[FLAG_N] ^ flags_reg[FLAG_V];    // see RULE5
      OP_BR_HALF_SET:       br_taken = flags_reg[FLAG_H];   // see RULE6
      OP_BR_HALF_CLEAR:     br_taken = !flags_reg[FLAG_H];  // see RULE6
      OP_BR_TRANSFER_SET:   br_taken = flags_reg[FLAG_T];   // see RULE7
      OP_BR_TRANSFER_CLEAR: br_taken = !flags_reg[FLAG_T];  // see RULE7
      OP_BR_OVF_SET:        br_taken = flags_reg[FLAG_V];   // see RULE8
      OP_BR_OVF_CLEAR:      br_taken = !flags_reg[FLAG_V];  // see RULE8
      OP_BR_IRQ_ENABLED:    br_taken = flags_reg[FLAG_I];   // see RULE9
      OP_BR_IRQ_DISABLED:   br_taken = !flags_reg[FLAG_I];  // see RULE9
      default:              br_taken = 1'b0;
    endcase
  end

  logic is_shift;
  logic exec_now;
  assign is_shift = (instr_reg.op inside {OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_SHR_SIGNED});
  assign exec_now = (state_reg == ST_EXEC);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      instr_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (issue_fire) begin
            instr_reg <= instr_s'(wdata);
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (br_taken) begin
            state_reg <= ST_BR_TAKEN;   // Taken branch costs a second cycle
          end else if (instr_reg.op == OP_LD_XINC) begin
            state_reg <= ST_LD_WAIT;    // see RULE19
          end else if (instr_reg.op == OP_LD_XDEC) begin
            state_reg <= ST_LD_ADDR;    // see RULE20
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_BR_TAKEN: state_reg <= ST_IDLE;
        ST_LD_ADDR:  state_reg <= ST_LD_WAIT;
        ST_LD_WAIT: begin
          if (ds_ack) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg    <= PC_W'(PC_RESET);
      taken_reg <= 1'b0;
    end else if (exec_now) begin
      taken_reg <= br_taken;
      pc_reg    <= br_taken ? br_target : pc_reg + PC_W'(1);
    end else if (wr_fire && adr_i == ADR_PC && state_reg == ST_IDLE) begin
      pc_reg <= (pc_reg & ~wmask[PC_W-1:0]) | wdata[PC_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= FLAGS_RESET;
    end else if (exec_now) begin
      if (is_shift) begin
        flags_reg[FLAG_C] <= shift_c;
        flags_reg[FLAG_Z] <= (shift_res == 8'h00);
        flags_reg[FLAG_N] <= shift_res[7];
        flags_reg[FLAG_V] <= shift_res[7] ^ shift_c;
        // Half-carry only moves on the left-going forms
        if (instr_reg.op == OP_SHL || instr_reg.op == OP_ROL) begin
          flags_reg[FLAG_H] <= src[3];                 // see RULE10, RULE12
        end
      end else if (instr_reg.op == OP_FLAG_SET) begin
        flags_reg[instr_reg.bit_sel] <= 1'b1;          // see RULE15
      end else if (instr_reg.op == OP_FLAG_CLR) begin
        flags_reg[instr_reg.bit_sel] <= 1'b0;          // see RULE15
      end else if (instr_reg.op == OP_BIT_TO_T) begin
        flags_reg[FLAG_T] <= src[instr_reg.bit_sel];   // see RULE17
      end
    end else if (wr_fire && adr_i == ADR_FLAGS && state_reg == ST_IDLE && sel_i[0]) begin
      flags_reg <= dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // X pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      xptr_reg <= XPTR_RESET;
    end else if (exec_now && instr_reg.op == OP_LD_XDEC) begin
      xptr_reg <= xptr_reg - 16'h0001;                 // see RULE20
    end else if (state_reg == ST_LD_WAIT && ds_ack && instr_reg.op == OP_LD_XINC) begin
      xptr_reg <= xptr_reg + 16'h0001;                 // see RULE19
    end else if (wr_fire && adr_i == ADR_XPTR && state_reg == ST_IDLE) begin
      xptr_reg <= (xptr_reg & ~wmask[15:0]) | wdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) begin
        regs_reg[i] <= 8'h00;
      end
    end else if (exec_now && is_shift) begin
      regs_reg[instr_reg.rd] <= shift_res;
    end else if (exec_now && instr_reg.op == OP_T_TO_BIT) begin
      regs_reg[instr_reg.rd][instr_reg.bit_sel] <= flags_reg[FLAG_T]; // see RULE18
    end else if (state_reg == ST_LD_WAIT && ds_ack) begin
      regs_reg[instr_reg.rd] <= ds_rdata;              // see RULE19, RULE20
    end else if (wr_fire && regs_hit && state_reg == ST_IDLE && sel_i[0]) begin
      regs_reg[regs_idx] <= dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Data-space request
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ds_req <= '0;
    end else if (exec_now && instr_reg.op == OP_LD_XINC) begin
      ds_req.valid <= 1'b1;                            // see RULE19
      ds_req.addr  <= xptr_reg;
    end else if (state_reg == ST_LD_ADDR) begin
      ds_req.valid <= 1'b1;                            // see RULE20
      ds_req.addr  <= xptr_reg;
    end else if (ds_ack) begin
      ds_req.valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // I/O bit pulse
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_bit <= '0;
    end else if (exec_now && (instr_reg.op == OP_IO_ONE || instr_reg.op == OP_IO_ZERO)) begin
      io_bit.valid   <= 1'b1;                          // see RULE16
      io_bit.addr    <= instr_reg.io_addr;
      io_bit.bit_sel <= instr_reg.bit_sel;
      io_bit.value   <= (instr_reg.op == OP_IO_ONE);
    end else begin
      io_bit.valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_fire;
      if (bus_fire && !we_i) begin
        if (regs_hit) begin
          rdata_reg <= {24'h00_0000, regs_reg[regs_idx]};
        end else begin
          unique case (adr_i)
            ADR_ISSUE:  rdata_reg <= 32'(instr_reg);
            ADR_STATUS: rdata_reg <= {30'h0000_0000, taken_reg, state_reg != ST_IDLE};
            ADR_FLAGS:  rdata_reg <= {24'h00_0000, flags_reg};
            ADR_PC:     rdata_reg <= 32'(pc_reg);
            ADR_XPTR:   rdata_reg <= {16'h0000, xptr_reg};
            default:    rdata_reg <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;
  assign pc    = pc_reg;

endmodule : branch_shift_flag_exec
`default_nettype wire

// ---- hdl/exec_pkg.sv ----
/*
  Constants, operation codes and carrier types for the branch, shift and
  flag execution block. Assumes a 32-bit classic Wishbone register bus.
*/
// Notes on behaviour
// (RULE1) Carry-clear and same-or-higher branch jump to pc+k+1 when carry is zero.
// (RULE2) Lower branch jumps to pc+k+1 only when carry is one.
// (RULE3) Negative branch jumps to pc+k+1 only when negative flag is one.
// (RULE4) Signed greater-or-equal branch jumps when negative xor overflow is zero.
// (RULE5) Signed less-than branch jumps when negative xor overflow is one.
// (RULE6) Half-carry branches jump on half-carry one (set) or zero (clear).
// (RULE7) Transfer branches jump on transfer flag one (set) or zero (clear).
// (RULE8) Overflow branches jump on overflow one (set) or zero (clear).
// (RULE9) Interrupt branches jump on global enable one or zero.
// (RULE10) Left shift moves bits up, bit zero gets zero; Z,C,N,V,H updated.
// (RULE11) Right shift moves bits down, bit seven gets zero; Z,C,N,V updated.
// (RULE12) Left rotate: old carry to bit zero, old bit seven to carry.
// (RULE13) Right rotate: old carry to bit seven, old bit zero to carry.
// (RULE14) Signed right shift keeps bit seven, old bit zero to carry.
// (RULE15) Flag set or clear writes one status flag, others untouched, one cycle.
// (RULE16) I/O bit force one or zero in one cycle, flags untouched.
// (RULE17) Bit store copies selected register bit into transfer flag only.
// (RULE18) Bit load copies transfer flag into selected register bit, flags untouched.
// (RULE19) Post-increment load reads byte at X, then X plus one; two cycles.
// (RULE20) Pre-decrement load first X minus one, then reads; three cycles.
`default_nettype none
package exec_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADR_ISSUE  = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_FLAGS  = 8'h08;
  localparam logic [7:0] ADR_PC     = 8'h0C;
  localparam logic [7:0] ADR_XPTR   = 8'h10;
  localparam logic [7:0] ADR_REGS   = 8'h40;

  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] XPTR_RESET  = 16'h0000;

  // ----------------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Status register bits
  localparam int STAT_BUSY  = 0;
  localparam int STAT_TAKEN = 1;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_BR_CARRY_CLEAR, OP_BR_SAME_HIGHER, OP_BR_LOWER, OP_BR_NEGATIVE,
    OP_BR_SIGNED_GE, OP_BR_SIGNED_LESS, OP_BR_HALF_SET, OP_BR_HALF_CLEAR,
    OP_BR_TRANSFER_SET, OP_BR_TRANSFER_CLEAR, OP_BR_OVF_SET, OP_BR_OVF_CLEAR,
    OP_BR_IRQ_ENABLED, OP_BR_IRQ_DISABLED,
    OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_SHR_SIGNED,
    OP_FLAG_SET, OP_FLAG_CLR, OP_IO_ONE, OP_IO_ZERO,
    OP_BIT_TO_T, OP_T_TO_BIT, OP_LD_XINC, OP_LD_XDEC
  } op_e;

  // Instruction word as written to the issue register
  typedef struct packed {
    logic [6:0] rsvd;
    logic [6:0] disp;
    logic [5:0] io_addr;
    logic [2:0] bit_sel;
    logic [3:0] rd;
    op_e        op;
  } instr_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } ds_req_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
    logic [2:0] bit_sel;
    logic       value;
  } io_bit_s;

endpackage : exec_pkg
`default_nettype wire

// ---- bench/exec_asserts.sv ----
/*
  Port-level assertions for branch_shift_flag_exec, bound to every instance.
  Assumes exec_pkg is compiled first and a single core clock domain.
*/
`default_nettype none
module exec_asserts
  import exec_pkg::*;
#(
  parameter int PC_W = 16
) (
  // Clock and reset
  input wire logic            core_clk,
  input wire logic            reset_n,
  // Register bus
  input wire logic            cyc_i,
  input wire logic            stb_i,
  input wire logic            we_i,
  input wire logic [7:0]      adr_i,
  input wire logic [3:0]      sel_i,
  input wire logic [31:0]     dat_i,
  input wire logic [31:0]     dat_o,
  input wire logic            ack_o,
  // Data space, I/O and program counter
  input wire ds_req_s         ds_req,
  input wire logic            ds_ack,
  input wire logic [7:0]      ds_rdata,
  input wire io_bit_s         io_bit,
  input wire logic [PC_W-1:0] pc
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // --------------------------------------------------------------------
  // Register bus handshake
  // --------------------------------------------------------------------
  property p_ack_next;
    (cyc_i && stb_i && !ack_o) |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");

  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

  property p_unmapped_zero;
    (ack_o && $past(cyc_i && !we_i && adr_i == 8'h20)) |-> dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  // --------------------------------------------------------------------
  // I/O bit pulses and data-space reads
  // --------------------------------------------------------------------
  property p_io_pulse;
    io_bit.valid |-> $past(ack_o && we_i && adr_i == ADR_ISSUE)
      && io_bit.value == ($past(dat_i[4:0]) == 5'h16) && io_bit.addr == $past(dat_i[17:12])
      && io_bit.bit_sel == $past(dat_i[11:9]) ##1 !io_bit.valid;
  endproperty
  a_io_pulse: assert property (p_io_pulse) else $error("io bit pulse wrong");

  property p_ds_hold;
    (ds_req.valid && !ds_ack) |=> ds_req.valid && $stable(ds_req.addr);
  endproperty
  a_ds_hold: assert property (p_ds_hold) else $error("read request dropped early");

  property p_ds_done;
    (ds_req.valid && ds_ack) |=> !ds_req.valid;
  endproperty
  a_ds_done: assert property (p_ds_done) else $error("read request after answer");

  property p_ds_start;
    $rose(ds_req.valid) |->
      ($past(ack_o && we_i && adr_i == ADR_ISSUE && dat_i[4:0] == 5'h1A))
      || ($past(ack_o && we_i && adr_i == ADR_ISSUE && dat_i[4:0] == 5'h1B, 2));
  endproperty
  a_ds_start: assert property (p_ds_start) else $error("read started off time");
endmodule : exec_asserts

bind branch_shift_flag_exec exec_asserts #(.PC_W(PC_W)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .ds_req(ds_req), .ds_ack(ds_ack), .ds_rdata(ds_rdata), .io_bit(io_bit), .pc(pc)
);
`default_nettype wire

// ---- bench/data_space_model.sv ----
/*
  Data-space responder: answers a read with address low byte xor 8'h5A.
  Assumes the requester holds valid and address until ds_ack is seen.
*/
`default_nettype none
module data_space_model
  import exec_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Request side
  input  wire ds_req_s    ds_req,
  input  wire logic       slow,
  output logic            ds_ack,
  output logic      [7:0] ds_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_reg;
  logic [7:0] last_reg;

  // Prompt mode answers in the cycle valid rises
  assign ds_ack   = ds_req.valid && (wait_reg == (slow ? 3'h3 : 3'h0));
  // Idle data is the inverse of the last answer, never a stale match
  assign ds_rdata = ds_ack ? (ds_req.addr[7:0] ^ 8'h5A) : ~last_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= 3'h0;
      last_reg <= 8'h00;
    end else begin
      wait_reg <= (ds_req.valid && !ds_ack) ? wait_reg + 3'h1 : 3'h0;
      if (ds_ack) begin
        last_reg <= ds_rdata;
      end
    end
  end
endmodule : data_space_model
`default_nettype wire

// ---- bench/branch_shift_flag_exec_tb_top.sv ----
/*
  Self-checking bench for branch_shift_flag_exec over classic Wishbone.
  Assumes exec_pkg, the checker and data_space_model are compiled first.
*/
`default_nettype none
module branch_shift_flag_exec_tb_top
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    op_e op; logic [7:0] fl; logic [7:0] rv; logic [2:0] b; logic [6:0] d;
    logic [15:0] epc; logic [7:0] ef; logic [7:0] er;
  } row_s;
  localparam logic [7:0] REG3 = ADR_REGS + 8'h0C;
  logic        core_clk, reset_n, cyc_i, stb_i, we_i, ack_o, ds_ack, slow;
  logic [7:0]  adr_i, ds_rdata;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [15:0] pc;
  ds_req_s     ds_req;
  io_bit_s     io_bit, io_seen;
  int          fail_count, num_checks, i;
  row_s        rows [26];

  branch_shift_flag_exec u_dut (.core_clk(core_clk), .reset_n(reset_n), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .ds_req(ds_req), .ds_ack(ds_ack), .ds_rdata(ds_rdata), .io_bit(io_bit),
    .pc(pc));
  data_space_model u_ds (.core_clk(core_clk), .reset_n(reset_n), .ds_req(ds_req),
    .slow(slow), .ds_ack(ds_ack), .ds_rdata(ds_rdata));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (io_bit.valid === 1'b1) io_seen <= io_bit;

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Holds the request until ack is sampled, then releases for a cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) chk("ack", 32'h0000_0001, 32'h0000_0000);
  endtask : wb

  task idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, ADR_STATUS, 32'h0000_0000);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 50);
    if (n >= 50) chk("busy", 32'h0000_0000, q);
  endtask : idle

  task run(input op_e op, input logic [2:0] b, input logic [5:0] io, input logic [6:0] d);
    instr_s ins;
    ins = '{7'h00, d, io, b, 4'h3, op};
    wb(1'b1, ADR_ISSUE, ins);
    idle();
  endtask : run

  task report_and_stop;
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    {reset_n, cyc_i, stb_i, we_i, slow} = 5'h00;
    {adr_i, sel_i, dat_i} = 44'h0;
    fail_count = 0;
    num_checks = 0;
    rows = '{
      '{OP_BR_CARRY_CLEAR, 8'h00, 8'h00, 3'h0, 7'h05, 16'h0016, 8'h00, 8'h00},
      '{OP_BR_CARRY_CLEAR, 8'h01, 8'h00, 3'h0, 7'h05, 16'h0011, 8'h01, 8'h00},
      '{OP_BR_SAME_HIGHER, 8'h00, 8'h00, 3'h0, 7'h7E, 16'h000F, 8'h00, 8'h00},
      '{OP_BR_LOWER, 8'h01, 8'h00, 3'h0, 7'h05, 16'h0016, 8'h01, 8'h00},
      '{OP_BR_LOWER, 8'h00, 8'h00, 3'h0, 7'h05, 16'h0011, 8'h00, 8'h00},
      '{OP_BR_NEGATIVE, 8'h04, 8'h00, 3'h0, 7'h05, 16'h0016, 8'h04, 8'h00},
      '{OP_BR_NEGATIVE, 8'h00, 8'h00, 3'h0, 7'h05, 16'h0011, 8'h00, 8'h00},
      '{OP_BR_SIGNED_GE, 8'h0C, 8'h00, 3'h0, 7'h05, 16'h0016, 8'h0C, 8'h00},
      '{OP_BR_SIGNED_GE, 8'h04, 8'h00, 3'h0, 7'h05, 16'h0011, 8'h04, 8'h00},
      '{OP_BR_SIGNED_LESS, 8'h08, 8'h00, 3'h0, 7'h05, 16'h0016, 8'h08, 8'h00},
      '{OP_BR_SIGNED_LESS, 8'h0C, 8'h00, 3'h0, 7'h05, 16'h0011, 8'h0C, 8'h00},
      '{OP_BR_HALF_SET, 8'h20, 8'h00, 3'h0, 7'h05, 16'h0016, 8'h20, 8'h00},
      '{OP_BR_HALF_CLEAR, 8'h20, 8'h00, 3'h0, 7'h05, 16'h0011, 8'h20, 8'h00},
      '{OP_BR_TRANSFER_SET, 8'h40, 8'h00, 3'h0, 7'h05, 16'h0016, 8'h40, 8'h00},
      '{OP_BR_TRANSFER_CLEAR, 8'h00, 8'h00, 3'h0, 7'h05, 16'h0016, 8'h00, 8'h00},
      '{OP_BR_OVF_SET, 8'h00, 8'h00, 3'h0, 7'h05, 16'h0011, 8'h00, 8'h00},
      '{OP_BR_OVF_CLEAR, 8'h00, 8'h00, 3'h0, 7'h05, 16'h0016, 8'h00, 8'h00},
      '{OP_BR_IRQ_ENABLED, 8'h80, 8'h00, 3'h0, 7'h05, 16'h0016, 8'h80, 8'h00},
      '{OP_BR_IRQ_DISABLED, 8'h80, 8'h00, 3'h0, 7'h05, 16'h0011, 8'h80, 8'h00},
      '{OP_SHL, 8'h00, 8'h88, 3'h0, 7'h00, 16'h0011, 8'h29, 8'h10},
      '{OP_SHR, 8'h04, 8'h01, 3'h0, 7'h00, 16'h0011, 8'h0B, 8'h00},
      '{OP_ROL, 8'h01, 8'h80, 3'h0, 7'h00, 16'h0011, 8'h09, 8'h01},
      '{OP_ROR, 8'h01, 8'h02, 3'h0, 7'h00, 16'h0011, 8'h0C, 8'h81},
      '{OP_SHR_SIGNED, 8'h00, 8'h81, 3'h0, 7'h00, 16'h0011, 8'h05, 8'hC0},
      '{OP_BIT_TO_T, 8'h00, 8'h20, 3'h5, 7'h00, 16'h0011, 8'h40, 8'h20},
      '{OP_T_TO_BIT, 8'h40, 8'h00, 3'h2, 7'h00, 16'h0011, 8'h40, 8'h04}};
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk("flags_rst", 32'h0000_0000, q);
    wb(1'b0, ADR_XPTR, 32'h0);
    chk("x_rst", 32'h0000_0000, q);
    foreach (rows[i]) begin
      wb(1'b1, ADR_PC, 32'h0000_0010);
      wb(1'b1, ADR_FLAGS, 32'(rows[i].fl));
      wb(1'b1, REG3, 32'(rows[i].rv));
      run(rows[i].op, rows[i].b, 6'h00, rows[i].d);
      chk("pc_out", 32'(rows[i].epc), 32'(pc));
      wb(1'b0, ADR_PC, 32'h0);
      chk("pc", 32'(rows[i].epc), q);
      wb(1'b0, ADR_FLAGS, 32'h0);
      chk("flags", 32'(rows[i].ef), q);
      wb(1'b0, REG3, 32'h0);
      chk("reg", 32'(rows[i].er), q);
    end
    for (i = 0; i < 8; i++) begin
      wb(1'b1, ADR_FLAGS, 32'h0000_0000);
      run(OP_FLAG_SET, 3'(i), 6'h00, 7'h00);
      wb(1'b0, ADR_FLAGS, 32'h0);
      chk("flag_set", 32'(8'h01 << i), q);
      wb(1'b1, ADR_FLAGS, 32'h0000_00FF);
      run(OP_FLAG_CLR, 3'(i), 6'h00, 7'h00);
      wb(1'b0, ADR_FLAGS, 32'h0);
      chk("flag_clr", 32'(8'hFF ^ (8'h01 << i)), q);
    end
    // ------------------------------------------------------------------
    // I/O bit forcing, loads, refusal, unmapped and mid-run reset
    // ------------------------------------------------------------------
    wb(1'b1, ADR_FLAGS, 32'h0000_005A);
    run(OP_IO_ONE, 3'h5, 6'h2A, 7'h00);
    chk("io_one", {21'h0, 1'b1, 6'h2A, 3'h5, 1'b1}, 32'(io_seen));
    run(OP_IO_ZERO, 3'h7, 6'h3F, 7'h00);
    chk("io_zero", {21'h0, 1'b1, 6'h3F, 3'h7, 1'b0}, 32'(io_seen));
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk("io_flags", 32'h0000_005A, q);
    wb(1'b1, ADR_XPTR, 32'h0000_0030);
    run(OP_LD_XINC, 3'h0, 6'h00, 7'h00);
    wb(1'b0, REG3, 32'h0);
    chk("ld_inc", 32'h0000_006A, q);
    wb(1'b0, ADR_XPTR, 32'h0);
    chk("x_inc", 32'h0000_0031, q);
    slow <= 1'b1;
    wb(1'b1, ADR_XPTR, 32'h0000_0040);
    wb(1'b1, ADR_FLAGS, 32'h0000_0000);
    wb(1'b1, ADR_ISSUE, {23'h0, 4'h3, 5'h1B});
    // Written while busy, so it must be dropped
    wb(1'b1, ADR_FLAGS, 32'h0000_00FF);
    idle();
    wb(1'b0, REG3, 32'h0);
    chk("ld_dec", 32'h0000_0065, q);
    wb(1'b0, ADR_XPTR, 32'h0);
    chk("x_dec", 32'h0000_003F, q);
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk("busy_drop", 32'h0000_0000, q);
    wb(1'b1, 8'h24, 32'hFFFF_FFFF);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0000_0000, q);
    wb(1'b1, ADR_PC, 32'h0000_1234);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    wb(1'b0, ADR_PC, 32'h0);
    chk("pc_rst", 32'h0000_0000, q);
    report_and_stop();
  end
endmodule : branch_shift_flag_exec_tb_top
`default_nettype wire
